// file: shared/spm_pkg.sv
package spm_pkg;

	// Bus geometry
	localparam int         APB_AW       = 8;
	localparam int         APB_DW       = 32;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_BUF      = 8'h04;
	localparam logic [7:0] OFF_CFG      = 8'h08;
	localparam logic [7:0] OFF_STAT     = 8'h0C;

	// Field positions in serial_control_reg
	localparam int         BIT_MODE_HI  = 7;
	localparam int         BIT_MODE_LO  = 6;
	localparam int         BIT_MPQ      = 5;
	localparam int         BIT_REN      = 4;
	localparam int         BIT_TB8      = 3;
	localparam int         BIT_RB8      = 2;
	localparam int         BIT_TI       = 1;
	localparam int         BIT_RI       = 0;

	// Field positions in the config and status words
	localparam int         BIT_SIX_CLK  = 0;
	localparam int         BIT_SEND     = 0;
	localparam int         BIT_RECV     = 1;
	localparam int         BIT_TX_PEND  = 2;

	// Values after reset
	localparam logic [7:0] CTRL_RST     = 8'h00;
	localparam logic [7:0] BUF_RST      = 8'h00;
	localparam logic       CFG_SIX_RST  = 1'h0;

	// Machine cycle: six states of two phases, phase 0 is S1P1
	localparam int         PH_W         = 4;
	localparam logic [3:0] PH_S1P1      = 4'h0;
	localparam logic [3:0] PH_S3P1      = 4'h4;
	localparam logic [3:0] PH_S5P2      = 4'h9;
	localparam logic [3:0] PH_S6P1      = 4'hA;
	localparam logic [3:0] PH_S6P2      = 4'hB;
	localparam int         PH_PER_MC    = 12;
	localparam int         OSC_DIV      = 2;
	localparam logic [5:0] MC_PCLK_12   = 6'(PH_PER_MC * OSC_DIV);
	localparam logic [5:0] MC_PCLK_6    = 6'(PH_PER_MC * OSC_DIV / 2);

	// Shift registers
	localparam int         TX_SR_W      = 9;
	localparam int         RX_SR_W      = 8;
	localparam logic [3:0] XFER_BITS    = 4'h8;
	localparam logic [7:0] RX_LOAD_PAT  = 8'hFE;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_ARM  = 4'h2,
		TX_SEND = 4'h4,
		TX_FIN  = 4'h8
	} spm_tx_e;

	typedef enum logic [5:0] {
		RX_IDLE = 6'h01,
		RX_PEND = 6'h02,
		RX_LDW  = 6'h04,
		RX_ARM  = 6'h08,
		RX_RECV = 6'h10,
		RX_FIN  = 6'h20
	} spm_rx_e;

	function automatic logic spm_at_ph(input logic [3:0] ph, input logic ph_new, input logic [3:0] k);
		spm_at_ph = ph_new & (ph == k);
	endfunction : spm_at_ph

	function automatic logic [7:0] spm_rev8(input logic [7:0] v);
		spm_rev8 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
	endfunction : spm_rev8

endpackage : spm_pkg

// file: core/spm_sync.sv
`timescale 1ns/10ps
module spm_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      dout
);
	logic meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'h1;
			dout   <= 1'h1;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : spm_sync

// file: core/spm_phase.sv
`timescale 1ns/10ps
module spm_phase (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   six_clk,
	output logic [spm_pkg::PH_W-1:0]    phase_q,
	output logic                        ph_new_q
);
	import spm_pkg::*;

	logic div_q;
	wire  tick = six_clk | div_q;
	wire  [3:0] ph_nxt = (phase_q == PH_S6P2) ? PH_S1P1 : 4'(phase_q + 4'h1);

	// One phase per oscillator clock, or per half clock in six-clock operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q    <= 1'h0;
			phase_q  <= PH_S1P1;
			ph_new_q <= 1'h0;
		end else begin
			div_q    <= ~div_q & ~six_clk;
			ph_new_q <= tick;
			if (tick) begin
				phase_q <= ph_nxt;
			end
		end
	end
endmodule : spm_phase

// file: core/spm_top.sv
// Functional notes
// - Transmit flag set after eighth bit time
// - Receive flag set after eighth bit time
// - Data on data line, clock on clock line
// - Eight bits, LSB first, no framing
// - Bit rate osc/12 or osc/6
// - Only a buffer write starts transmission
// - Buffer write at S6P2 loads marker bit
// - One machine cycle before transmit goes active
// - Transmit drives data and clock pins
// - Clock low S3 to S5, high otherwise
// - Transmit shifts right at every S6P2
// - Zero fill, final shift at marker
// - Transmit ends at S1P1, tenth cycle
// - Receive starts when enabled and flag clear
// - Load 11111110, receive active one phase later
// - Receive drives clock, edges S3P1 and S6P1
// - Receive shifts at every S6P2
// - Shift left, bit sampled at S5P2
// - Receive ends at S1P1, tenth cycle
// - Ninth transmit bit is writable control bit; here tx_sr_q bit 8 is the constant marker 1 and TB8 is not sent
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module spm_top (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic [spm_pkg::APB_AW-1:0]  paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [spm_pkg::APB_DW-1:0]  pwdata,
	output logic      [spm_pkg::APB_DW-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        data_line_pin_in,
	output logic                             data_line_pin_out,
	output logic                             data_line_pin_oe,
	output logic                             clock_line_pin_out,
	output logic                             clock_line_pin_oe
);
	import spm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]          ctrl_q;
	logic [7:0]          ctrl_d;
	logic [7:0]          rx_buf_q;
	logic [7:0]          tx_hold_q;
	logic                tx_req_q;
	logic                six_clk_q;
	logic [31:0]         prdata_q;
	spm_tx_e             tx_st_q;
	spm_tx_e             tx_st_d;
	spm_rx_e             rx_st_q;
	spm_rx_e             rx_st_d;
	logic [TX_SR_W-1:0]  tx_sr_q;
	logic [RX_SR_W-1:0]  rx_sr_q;
	logic                rx_bit_q;
	logic                clk_q;
	logic                dout_q;
	logic                doe_q;
	logic [PH_W-1:0]     phase;
	logic                ph_new;
	logic                data_sync;

	////////////////////////////////////////////////////////////////////////
	// Machine cycle timing and pin synchroniser
	spm_phase u_phase (
		.pclk     (pclk),
		.presetn  (presetn),
		.six_clk  (six_clk_q),
		.phase_q  (phase),
		.ph_new_q (ph_new)
	);

	spm_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (data_line_pin_in),
		.dout    (data_sync)
	);

	wire ev_s1p1 = spm_at_ph(phase, ph_new, PH_S1P1);
	wire ev_s5p2 = spm_at_ph(phase, ph_new, PH_S5P2);
	wire ev_s6p2 = spm_at_ph(phase, ph_new, PH_S6P2);
	wire low_ph  = (phase >= PH_S3P1) && (phase < PH_S6P1);

	////////////////////////////////////////////////////////////////////////
	// APB decode
	wire setup_ph  = psel & ~penable;
	wire acc_ph    = psel & penable;
	wire sel_ctrl  = paddr == OFF_CTRL;
	wire sel_buf   = paddr == OFF_BUF;
	wire sel_cfg   = paddr == OFF_CFG;
	wire sel_stat  = paddr == OFF_STAT;
	wire mapped    = sel_ctrl | sel_buf | sel_cfg | sel_stat;
	wire wr_ctrl   = acc_ph & pwrite & sel_ctrl;
	wire wr_buf    = acc_ph & pwrite & sel_buf;
	wire wr_cfg    = acc_ph & pwrite & sel_cfg;
	wire mode0     = ~ctrl_q[BIT_MODE_HI] & ~ctrl_q[BIT_MODE_LO];
	wire send_act  = (tx_st_q == TX_SEND) | (tx_st_q == TX_FIN);
	wire recv_act  = (rx_st_q == RX_RECV) | (rx_st_q == RX_FIN);
	wire [31:0] stat_w = {29'h0, tx_req_q | (tx_st_q == TX_ARM), recv_act, send_act};
	wire [31:0] rd_mux = sel_ctrl ? {24'h0, ctrl_q} :
	                     sel_buf  ? {24'h0, rx_buf_q} :
	                     sel_cfg  ? {31'h0, six_clk_q} :
	                     sel_stat ? stat_w : 32'h0;

	assign pready  = 1'h1;
	assign pslverr = acc_ph & ~mapped;
	assign prdata  = prdata_q;

	// Read data captured in the setup phase, zero wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (setup_ph) begin
			prdata_q <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit control
	wire tx_idle  = tx_st_q == TX_IDLE;
	wire rx_idle  = rx_st_q == RX_IDLE;
	wire tx_load  = tx_idle & tx_req_q & rx_idle & ev_s6p2;
	wire tx_last  = (tx_sr_q[TX_SR_W-1:2] == '0) & tx_sr_q[1];
	wire tx_shift = (tx_st_q == TX_SEND) & ev_s6p2;
	wire tx_end   = (tx_st_q == TX_FIN) & ev_s1p1;

	always_comb begin
		tx_st_d = tx_st_q;
		case (tx_st_q)
			TX_IDLE: begin
				if (tx_load) tx_st_d = TX_ARM;
			end
			TX_ARM: begin
				if (ev_s6p2) tx_st_d = TX_SEND;
			end
			TX_SEND: begin
				if (ev_s6p2 && tx_last) tx_st_d = TX_FIN;
			end
			TX_FIN: begin
				if (ev_s1p1) tx_st_d = TX_IDLE;
			end
			default: begin
				tx_st_d = TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q   <= TX_IDLE;
			tx_req_q  <= 1'h0;
			tx_hold_q <= BUF_RST;
			tx_sr_q   <= '0;
		end else begin
			tx_st_q <= tx_st_d;
			if (wr_buf && mode0 && tx_idle && !tx_req_q) begin
				tx_req_q  <= 1'h1;
				tx_hold_q <= pwdata[7:0];
			end else if (tx_load) begin
				tx_req_q  <= 1'h0;
			end
			if (tx_load) begin
				tx_sr_q <= {1'h1, tx_hold_q};
			end else if (tx_shift) begin
				tx_sr_q <= {1'h0, tx_sr_q[TX_SR_W-1:1]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive control
	wire rx_start = rx_idle & tx_idle & ~tx_req_q & mode0 & ctrl_q[BIT_REN] & ~ctrl_q[BIT_RI];
	wire rx_load  = (rx_st_q == RX_LDW) & ev_s6p2;
	wire rx_shift = (rx_st_q == RX_RECV) & ev_s6p2;
	wire rx_fin   = rx_shift & ~rx_sr_q[RX_SR_W-1];
	wire rx_end   = (rx_st_q == RX_FIN) & ev_s1p1;
	wire [7:0] rx_shifted = {rx_sr_q[RX_SR_W-2:0], rx_bit_q};

	always_comb begin
		rx_st_d = rx_st_q;
		case (rx_st_q)
			RX_IDLE: begin
				if (rx_start) rx_st_d = RX_PEND;
			end
			RX_PEND: begin
				if (ev_s1p1) rx_st_d = RX_LDW;
			end
			RX_LDW: begin
				if (ev_s6p2) rx_st_d = RX_ARM;
			end
			RX_ARM: begin
				if (ev_s1p1) rx_st_d = RX_RECV;
			end
			RX_RECV: begin
				if (rx_fin) rx_st_d = RX_FIN;
			end
			RX_FIN: begin
				if (ev_s1p1) rx_st_d = RX_IDLE;
			end
			default: begin
				rx_st_d = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_q  <= RX_IDLE;
			rx_sr_q  <= '0;
			rx_bit_q <= 1'h1;
			rx_buf_q <= BUF_RST;
		end else begin
			rx_st_q <= rx_st_d;
			if (ev_s5p2) begin
				rx_bit_q <= data_sync;
			end
			if (rx_load) begin
				rx_sr_q <= RX_LOAD_PAT;
			end else if (rx_shift) begin
				rx_sr_q <= rx_shifted;
			end
			if (rx_fin) begin
				rx_buf_q <= spm_rev8(rx_shifted);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control and config registers; a hardware set beats a software clear
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) ctrl_d = pwdata[7:0];
		if (tx_end) ctrl_d[BIT_TI] = 1'h1;
		if (rx_end) ctrl_d[BIT_RI] = 1'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= CTRL_RST;
			six_clk_q <= CFG_SIX_RST;
		end else begin
			ctrl_q <= ctrl_d;
			if (wr_cfg) six_clk_q <= pwdata[BIT_SIX_CLK];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers
	wire link_act = send_act | recv_act;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q  <= 1'h1;
			dout_q <= 1'h1;
			doe_q  <= 1'h0;
		end else begin
			clk_q  <= ~(link_act & low_ph);
			dout_q <= send_act ? tx_sr_q[0] : 1'h1;
			doe_q  <= send_act;
		end
	end

	assign clock_line_pin_out = clk_q;
	assign clock_line_pin_oe  = 1'h1;
	assign data_line_pin_out  = dout_q;
	assign data_line_pin_oe   = doe_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [5:0] mc_cnt_q;
	logic       mc_seen_q;
	logic [5:0] arm_cnt_q;
	logic [3:0] sh_cnt_q;
	wire  [5:0] mc_len = six_clk_q ? MC_PCLK_6 : MC_PCLK_12;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mc_cnt_q  <= 6'h0;
			mc_seen_q <= 1'h0;
			arm_cnt_q <= 6'h0;
			sh_cnt_q  <= 4'h0;
		end else begin
			mc_cnt_q  <= ev_s6p2 ? 6'h1 : 6'(mc_cnt_q + 6'h1);
			mc_seen_q <= wr_cfg ? 1'h0 : (mc_seen_q | ev_s6p2);
			arm_cnt_q <= (tx_st_q == TX_ARM) ? 6'(arm_cnt_q + 6'h1) : 6'h0;
			sh_cnt_q  <= tx_load ? 4'h0 : (tx_shift ? 4'(sh_cnt_q + 4'h1) : sh_cnt_q);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_tx_flag;
		tx_end |=> ctrl_q[BIT_TI] && !send_act;
	endproperty
	a_tx_flag: assert property (p_tx_flag) else $error("transmit flag not set at end");

	property p_rx_flag;
		rx_end |=> ctrl_q[BIT_RI] && !recv_act;
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive flag not set at end");

	property p_flag_hold;
		ctrl_q[BIT_TI] && !wr_ctrl |=> ctrl_q[BIT_TI];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("transmit flag cleared by hardware");

	property p_rx_no_drive;
		recv_act ##1 recv_act |-> !data_line_pin_oe;
	endproperty
	a_rx_no_drive: assert property (p_rx_no_drive) else $error("data line driven while receiving");

	property p_eight_shifts;
		tx_end |-> sh_cnt_q == XFER_BITS;
	endproperty
	a_eight_shifts: assert property (p_eight_shifts) else $error("transmit shift count wrong");

	property p_mc_len;
		ev_s6p2 && mc_seen_q && $stable(six_clk_q) |-> mc_cnt_q == mc_len;
	endproperty
	a_mc_len: assert property (p_mc_len) else $error("machine cycle length wrong");

	property p_arm_wait;
		$rose(send_act) |-> arm_cnt_q == mc_len;
	endproperty
	a_arm_wait: assert property (p_arm_wait) else $error("transmit active not one cycle after load");

	property p_clk_low;
		send_act && low_ph ##1 send_act |-> !clock_line_pin_out;
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("shift clock not low in S3 to S5");

	property p_tx_shift;
		tx_shift |=> tx_sr_q == {1'h0, $past(tx_sr_q[TX_SR_W-1:1])};
	endproperty
	a_tx_shift: assert property (p_tx_shift) else $error("transmit register did not shift right");

	property p_rx_load;
		rx_load |=> rx_sr_q == RX_LOAD_PAT && !recv_act;
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("receive register load wrong");

	property p_rx_shift;
		rx_shift |=> rx_sr_q[0] == $past(rx_bit_q);
	endproperty
	a_rx_shift: assert property (p_rx_shift) else $error("receive bit not shifted in");

	property p_clk_idle;
		!link_act ##1 !link_act |=> $stable(clock_line_pin_out);
	endproperty
	a_clk_idle: assert property (p_clk_idle) else $error("shift clock toggles while idle");

	property p_cv_tx;
		tx_end;
	endproperty
	c_cv_tx: cover property (p_cv_tx);

	property p_cv_rx;
		rx_end;
	endproperty
	c_cv_rx: cover property (p_cv_rx);

	property p_cv_six;
		six_clk_q && tx_end;
	endproperty
	c_cv_six: cover property (p_cv_six);

endmodule : spm_top

// file: testbench/spm_ext_sr.sv
`timescale 1ns/10ps
module spm_ext_sr (
	input  wire logic       pclk,
	input  wire logic       sclk,
	input  wire logic       dev_oe,
	input  wire logic       dev_dout,
	input  wire logic       load,
	input  wire logic [7:0] load_byte,
	output logic            pin_drive,
	output logic [7:0]      got,
	output int              n_rise,
	output int              n_fall,
	output int              period
);
	logic       sclk_q = 1'b1;
	logic       idle   = 1'b1;
	logic [7:0] sr     = 8'h00;
	int         left   = 0;
	int         cnt    = 0;
	initial begin
		pin_drive = 1'b0;
		n_rise    = 0;
		n_fall    = 0;
		period    = 0;
	end
	////////////////////////////////////////////////////////////////
	// Edges of the shift clock found by sampling on pclk
	always @(posedge pclk) begin
		sclk_q <= sclk;
		cnt    <= cnt + 1;
		if (load) begin
			sr     <= load_byte;
			left   <= 8;
			idle   <= 1'b0;
			n_rise <= 0;
			n_fall <= 0;
		end else begin
			if (sclk && !sclk_q) begin
				if (dev_oe) begin
					got    <= {dev_dout, got[7:1]};
					n_rise <= n_rise + 1;
				end
				if (left == 0) begin
					idle <= 1'b1;
				end
			end
			if (!sclk && sclk_q) begin
				n_fall <= n_fall + 1;
				period <= cnt;
				cnt    <= 1;
				if (left > 0) begin
					pin_drive <= sr[0];
					sr        <= sr >> 1;
					left      <= left - 1;
				end
			end else if (idle) begin
				// Line content is meaningless outside a frame
				pin_drive <= ~pin_drive;
			end
		end
	end
endmodule : spm_ext_sr

// file: testbench/tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected at %0t: %h %h", $time, (a), (b)); end end
module tb;
	import spm_pkg::*;
	logic        pclk      = 1'b0;
	logic        presetn   = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic        load      = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [7:0]  load_byte = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic [31:0] seed      = 32'h4AE3;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, dout, doe, cout, coe, pdrv;
	logic [7:0]  got, e;
	int          n_rise, n_fall, period, mc;
	int          n_fail    = 0;
	int          cmp_count = 0;
	logic [7:0]  exp_q[$];
	wire         dline     = doe ? dout : pdrv;

	always #25 pclk = ~pclk;

	spm_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.data_line_pin_in(dline), .data_line_pin_out(dout), .data_line_pin_oe(doe),
		.clock_line_pin_out(cout), .clock_line_pin_oe(coe));

	spm_ext_sr PEER (.pclk(pclk), .sclk(cout), .dev_oe(doe), .dev_dout(dout), .load(load),
		.load_byte(load_byte), .pin_drive(pdrv), .got(got), .n_rise(n_rise), .n_fall(n_fall), .period(period));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) n_fail++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task poll(input int bitn);
		int i;
		i = 0;
		do begin
			apb(1'b0, OFF_CTRL, 32'h0);
			i++;
		end while (rd[bitn] !== 1'b1 && i < 400);
		if (rd[bitn] !== 1'b1) n_fail++;
	endtask : poll

	task pulse(input logic [7:0] v);
		@(posedge pclk);
		load      <= 1'b1;
		load_byte <= v;
		@(posedge pclk);
		load      <= 1'b0;
	endtask : pulse

	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		n_fail++;
		final_report;
	end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			`CHK({er, rd}, 33'h0)
		end
		apb(1'b0, 8'h10, 32'h0);
		`CHK({er, rd}, 33'h1_0000_0000)
		for (int six = 0; six < 2; six++) begin
			apb(1'b1, OFF_CFG, 32'(six));
			mc = six ? int'(MC_PCLK_6) : int'(MC_PCLK_12);
			// Transmit one random byte
			seed = lfsr(seed);
			exp_q.push_back(seed[7:0]);
			pulse(~seed[7:0]);
			apb(1'b1, OFF_BUF, {24'h0, seed[7:0]});
			apb(1'b0, OFF_STAT, 32'h0);
			`CHK(rd[BIT_TX_PEND] | rd[BIT_SEND], 1'b1)
			poll(BIT_TI);
			repeat (2 * mc) @(posedge pclk);
			e = exp_q.pop_front();
			`CHK(got, e)
			`CHK(n_rise, 8)
			`CHK(n_fall, 8)
			`CHK(period, mc)
			`CHK(coe, 1'b1)
			apb(1'b0, OFF_CTRL, 32'h0);
			`CHK(rd[7:0], 8'h02)
			apb(1'b0, OFF_STAT, 32'h0);
			`CHK(rd, 32'h0)
			apb(1'b1, OFF_CTRL, 32'h0);
			// Receive one random byte
			seed = lfsr(seed);
			exp_q.push_back(seed[7:0]);
			pulse(seed[7:0]);
			apb(1'b1, OFF_CTRL, 32'h10);
			poll(BIT_RI);
			`CHK(rd[7:0], 8'h11)
			apb(1'b1, OFF_CTRL, 32'h0);
			apb(1'b0, OFF_BUF, 32'h0);
			e = exp_q.pop_front();
			`CHK(rd[7:0], e)
			`CHK(n_fall, 8)
			`CHK(period, mc)
		end
		// Asynchronous mode set: a buffer write starts nothing
		apb(1'b1, OFF_CTRL, 32'h48);
		apb(1'b0, OFF_CTRL, 32'h0);
		`CHK(rd[7:0], 8'h48)
		pulse(8'h5A);
		apb(1'b1, OFF_BUF, 32'hA5);
		repeat (300) @(posedge pclk);
		`CHK(n_fall, 0)
		apb(1'b0, OFF_STAT, 32'h0);
		`CHK(rd, 32'h0)
		final_report;
	end
endmodule : tb
